// File: hdl/sea_pkg.sv
// shared constants and types for the serial eeprom link ends
package sea_pkg;
  localparam int CLK_HZ = 10_000_000;
  // self-timed write cycle
  localparam int TWR_MS = 5;
  localparam int TWR_CYC = TWR_MS * (CLK_HZ / 1000);
  // serial clock made by the host
  localparam int SCL_KHZ = 100;
  localparam int SCL_QTR_CYC = CLK_HZ / (SCL_KHZ * 1000 * 4);
  // memory shape
  localparam int MEM_AW = 15;
  localparam int PAGE_BITS = 6;
  localparam int FIFO_DEPTH = 32;
  // slave address fields; type code value is arbitrary
  localparam logic [3:0] TYPE_CODE = 4'h6;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] ST_FIN = 4'hf;
  typedef enum logic [1:0] {OP_WRITE, OP_POLL, OP_RD_CUR, OP_RD_RAND} sea_op_e;
endpackage

// File: hdl/sea_if.sv
// two-wire bus carrier joining host and device ends
`timescale 1ns/10ps
interface sea_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire sda;
  // open-drain wired-and with pull-up
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface

// File: hdl/sea_dev.sv
// serial eeprom slave end: bus logic on link_clk, write timer on clk
//
// Operation
// - busy device leaves write address unacknowledged
// - idle device acknowledges write address again
// - stop starts write; polling may follow
// - read framed like write, direction bit one
// - counter holds last accessed address plus one
// - current read acks, sends counter byte msb-first
// - master nack then stop ends read
// - read after top location returns location zero
// - random read: dummy write, repeated start, read
// - random read returns byte at loaded address
// - each master ack fetches next byte
// - master ends sequential read with nack, stop
// - fifteen-bit counter wraps 32767 to 0
// - answer only matching type code and selects
// - two word-address bytes load the counter
// - no response during internal programming
`timescale 1ns/10ps
module sea_dev
  import sea_pkg::*;
#(
  parameter int AW = MEM_AW,
  parameter int TWR_CYCLES = TWR_CYC
) (
  // clocks and reset
  input wire logic clk,
  input wire logic link_clk,
  input wire logic rst,
  input wire logic ce,
  // two-wire bus
  sea_if.dev bus,
  // straps and status
  input wire logic [2:0] chip_select_pins,
  output logic busy
);

  if (AW < 1 || AW > 16 || TWR_CYCLES < 1) begin : g_chk
    $error("sea_dev: bad parameters");
  end

  localparam int TW = $clog2(TWR_CYCLES + 1);
  // a memory smaller than a page rolls over its whole range
  localparam int PB = (AW < PAGE_BITS) ? AW : PAGE_BITS;
  localparam logic [AW-1:0] PMASK = AW'((1 << PB) - 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } sea_dst_e;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: pin synchronisers and bus events

  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic [1:0] ce_sy;
  logic [1:0] busy_sy;
  logic [2:0] cs_s1;
  logic [2:0] cs_s2;
  logic scl_q;
  logic sda_q;
  logic ce_l;
  logic start_c;
  logic stop_c;
  logic rise;
  logic fall;

  // every pin passes two flops before any logic looks at it
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      ce_sy <= 2'h0;
      busy_sy <= 2'h0;
      cs_s1 <= 3'h0;
      cs_s2 <= 3'h0;
    end else begin
      scl_sy <= {scl_sy[0], bus.scl};
      sda_sy <= {sda_sy[0], bus.sda};
      ce_sy <= {ce_sy[0], ce};
      busy_sy <= {busy_sy[0], busy};
      cs_s1 <= chip_select_pins;
      cs_s2 <= cs_s1;
    end
  end

  assign ce_l = ce_sy[1];

  // previous line levels for edge and condition detection
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_l) begin
      scl_q <= scl_sy[1];
      sda_q <= sda_sy[1];
    end
  end

  // data moving while scl high marks start or stop
  assign start_c = ce_l & scl_sy[1] & scl_q & sda_q & ~sda_sy[1];
  assign stop_c = ce_l & scl_sy[1] & scl_q & ~sda_q & sda_sy[1];
  assign rise = ce_l & scl_sy[1] & ~scl_q;
  assign fall = ce_l & ~scl_sy[1] & scl_q;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: slave state machine

  sea_dst_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] sh_reg;
  logic rw_reg;
  logic [1:0] rx_idx_reg;
  logic [7:0] addr_hi_reg;
  logic [AW-1:0] addr_reg;
  logic wr_pend_reg;
  logic wr_tgl_reg;
  logic hold_reg;
  logic ack_in_reg;
  logic sda_oe_reg;
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rd_byte;
  logic [15:0] word_addr;
  logic busy_eff;
  logic load_now;
  logic mem_we;
  logic addr_hit;

  assign rd_byte = mem[addr_reg];
  assign word_addr = {addr_hi_reg, sh_reg};
  // local hold covers the crossing delay before the timer's busy returns
  assign busy_eff = busy_sy[1] | hold_reg;
  assign addr_hit = (sh_reg[7:4] == TYPE_CODE) && (sh_reg[3:1] == cs_s2);
  // fetch a byte after a read address ack or a master ack
  assign load_now = fall & ((state_reg == ST_DEV_ACK && rw_reg == RW_READ) ||
                            (state_reg == ST_TX_ACK && ack_in_reg));
  assign mem_we = fall & (state_reg == ST_RX) & (bit_cnt_reg == BIT_LAST) &
                  (rx_idx_reg == 2'h2) & ~start_c & ~stop_c;

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      rw_reg <= RW_WRITE;
      rx_idx_reg <= 2'h0;
      addr_hi_reg <= 8'h00;
      addr_reg <= '0;
      wr_pend_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
      ack_in_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_c) begin
      // any start resynchronises to a fresh address byte
      state_reg <= ST_DEV;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_c) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
      if (wr_pend_reg) begin
        wr_tgl_reg <= ~wr_tgl_reg;
        wr_pend_reg <= 1'b0;
      end
    end else if (load_now) begin
      // first bit goes out now, counter moves past this byte
      sda_oe_reg <= ~rd_byte[7];
      sh_reg <= {rd_byte[6:0], 1'b0};
      bit_cnt_reg <= 4'h1;
      addr_reg <= addr_reg + 1'b1;
      state_reg <= ST_TX;
    end else begin
      case (state_reg)
        ST_DEV, ST_RX: begin
          if (rise && bit_cnt_reg != BIT_LAST) begin
            sh_reg <= {sh_reg[6:0], sda_sy[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (fall && bit_cnt_reg == BIT_LAST) begin
            if (state_reg == ST_DEV) begin
              if (addr_hit && !busy_eff) begin
                sda_oe_reg <= 1'b1;
                rw_reg <= sh_reg[0];
                state_reg <= ST_DEV_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else begin
              sda_oe_reg <= 1'b1;
              state_reg <= ST_RX_ACK;
              if (rx_idx_reg != 2'h2) begin
                rx_idx_reg <= rx_idx_reg + 2'h1;
              end
              if (rx_idx_reg == 2'h0) begin
                addr_hi_reg <= sh_reg;
              end else if (rx_idx_reg == 2'h1) begin
                addr_reg <= word_addr[AW-1:0];
              end else begin
                // page write: low bits roll within the page
                addr_reg <= (addr_reg & ~PMASK) | ((addr_reg + 1'b1) & PMASK);
                wr_pend_reg <= 1'b1;
              end
            end
          end
        end
        ST_DEV_ACK: begin
          if (fall) begin
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            rx_idx_reg <= 2'h0;
            state_reg <= ST_RX;
          end
        end
        ST_RX_ACK: begin
          if (fall) begin
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_RX;
          end
        end
        ST_TX: begin
          if (fall) begin
            if (bit_cnt_reg == BIT_LAST) begin
              sda_oe_reg <= 1'b0; // release for the master's ack
              state_reg <= ST_TX_ACK;
            end else begin
              sda_oe_reg <= ~sh_reg[7];
              sh_reg <= {sh_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (rise) begin
            ack_in_reg <= ~sda_sy[1];
          end
          if (fall) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // storage has no reset; contents survive bus resets
  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      mem[addr_reg] <= sh_reg;
    end
  end

  // hold busy locally from stop until the timer's busy is seen
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      hold_reg <= 1'b0;
    end else if (ce_l) begin
      if (stop_c && wr_pend_reg) begin
        hold_reg <= 1'b1;
      end else if (busy_sy[1]) begin
        hold_reg <= 1'b0;
      end
    end
  end

  assign bus.dev_sda_oe = sda_oe_reg;
  assign bus.dev_sda_o = 1'b0; // open drain: only ever pulls low

  ////////////////////////////////////////////////////////////////////////////
  // clk domain: self-timed write cycle

  logic [2:0] tgl_sy;
  logic [TW-1:0] twr_cnt_reg;

  // toggle crossing; only the second and third flops feed the edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgl_sy <= 3'h0;
    end else if (ce) begin
      tgl_sy <= {tgl_sy[1:0], wr_tgl_reg};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      twr_cnt_reg <= '0;
      busy <= 1'b0;
    end else if (ce) begin
      if (tgl_sy[2] ^ tgl_sy[1]) begin
        twr_cnt_reg <= TW'(TWR_CYCLES - 1);
        busy <= 1'b1;
      end else if (twr_cnt_reg != '0) begin
        twr_cnt_reg <= twr_cnt_reg - 1'b1;
      end else begin
        busy <= 1'b0;
      end
    end
  end

endmodule

// File: hdl/sea_host.sv
// two-wire bus master end with read-data fifo
`timescale 1ns/10ps
module sea_fifo
  import sea_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("sea_fifo: depth must be a power of two");
  end
  logic [W-1:0] buf_mem [0:DEPTH-1];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = buf_mem[rd_ptr[PW-1:0]];
  // pointers carry one wrap bit so full and empty differ
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce) begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (ce && in_valid && in_ready) begin
      buf_mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end
endmodule

module sea_host
  import sea_pkg::*;
#(
  parameter int QTR = SCL_QTR_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // two-wire bus
  sea_if.host bus,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sea_op_e cmd_op,
  input wire logic [2:0] cmd_sel,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] cmd_len,
  output logic done,
  output logic done_ack_ok,
  // read data
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);
  if (QTR < 4 || QTR > 255) begin : g_chk
    $error("sea_host: QTR out of range");
  end
  typedef enum logic [2:0] {A_IDLE, A_NEXT, A_START, A_STOP, A_TX, A_RX, A_DONE} sea_act_e;
  typedef struct packed {
    sea_act_e act;
    logic [7:0] byte_v;
  } sea_step_s;

  sea_act_e act_reg;
  sea_op_e op_reg;
  logic [3:0] st_reg;
  logic [2:0] sel_reg;
  logic [15:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] rem_reg;
  logic [7:0] q_reg;
  logic [1:0] ph_reg;
  logic [3:0] bc_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic nack_reg;
  logic push_reg;
  logic scl_reg;
  logic sda_oe_reg;
  logic [1:0] sda_sy;
  logic tick;
  logic f_ready;
  logic f_valid;
  logic [7:0] f_data;
  logic f_pop;
  sea_step_s step;

  // operation script: which bus action comes at each stage
  function automatic sea_step_s plan(sea_op_e op, logic [3:0] st, logic [2:0] sel,
                                      logic [15:0] a, logic [7:0] d);
    logic [7:0] dw;
    logic [7:0] dr;
    sea_step_s s;
    dw = {TYPE_CODE, sel, RW_WRITE};
    dr = {TYPE_CODE, sel, RW_READ};
    s = '{A_DONE, 8'h00};
    if (st == ST_FIN) begin
      s = '{A_DONE, 8'h00};
    end else if (st == 4'h0) begin
      s = '{A_START, 8'h00};
    end else if (op == OP_POLL) begin
      s = (st == 4'h1) ? '{A_TX, dw} : (st == 4'h2) ? '{A_STOP, 8'h00} : s;
    end else if (op == OP_RD_CUR) begin
      s = (st == 4'h1) ? '{A_TX, dr} : (st == 4'h2) ? '{A_RX, 8'h00} :
          (st == 4'h3) ? '{A_STOP, 8'h00} : s;
    end else if (st == 4'h1) begin
      s = '{A_TX, dw};
    end else if (st == 4'h2) begin
      s = '{A_TX, a[15:8]};
    end else if (st == 4'h3) begin
      s = '{A_TX, a[7:0]};
    end else if (op == OP_WRITE) begin
      s = (st == 4'h4) ? '{A_TX, d} : (st == 4'h5) ? '{A_STOP, 8'h00} : s;
    end else begin
      // random read: repeated start, then read address
      s = (st == 4'h4) ? '{A_START, 8'h00} : (st == 4'h5) ? '{A_TX, dr} :
          (st == 4'h6) ? '{A_RX, 8'h00} : (st == 4'h7) ? '{A_STOP, 8'h00} : s;
    end
    return s;
  endfunction

  assign step = plan(op_reg, st_reg, sel_reg, addr_reg, data_reg);
  assign tick = ce && q_reg == 8'(QTR - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and quarter-bit timer

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_sy <= 2'h3;
    end else begin
      sda_sy <= {sda_sy[0], bus.sda};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_reg <= 8'h00;
    end else if (ce) begin
      q_reg <= (act_reg inside {A_START, A_STOP, A_TX, A_RX} && !tick) ?
               q_reg + 8'h01 : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus sequencer

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_reg <= A_IDLE;
      op_reg <= OP_WRITE;
      st_reg <= 4'h0;
      sel_reg <= 3'h0;
      addr_reg <= 16'h0000;
      data_reg <= 8'h00;
      rem_reg <= 8'h00;
      ph_reg <= 2'h0;
      bc_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      nack_reg <= 1'b0;
      push_reg <= 1'b0;
      scl_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
      cmd_ready <= 1'b0;
      done <= 1'b0;
      done_ack_ok <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      push_reg <= 1'b0;
      case (act_reg)
        A_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op_reg <= cmd_op;
            sel_reg <= cmd_sel;
            addr_reg <= cmd_addr;
            data_reg <= cmd_data;
            rem_reg <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
            st_reg <= 4'h0;
            nack_reg <= 1'b0;
            act_reg <= A_NEXT;
          end
        end
        A_NEXT: begin
          // a read byte waits for fifo room, holding scl low
          if (step.act == A_DONE) begin
            done <= 1'b1;
            done_ack_ok <= ~nack_reg;
            act_reg <= A_IDLE;
          end else if (step.act != A_RX || f_ready) begin
            act_reg <= step.act;
            ph_reg <= 2'h0;
            bc_reg <= 4'h0;
            tx_reg <= step.byte_v;
            scl_reg <= 1'b0;
            sda_oe_reg <= (step.act == A_STOP) ||
                          (step.act == A_TX && !step.byte_v[7]);
          end
        end
        A_DONE: begin
          act_reg <= A_IDLE;
        end
        default: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h0) begin
              scl_reg <= 1'b1;
            end else if (ph_reg == 2'h1) begin
              // mid-high: conditions and sampling
              if (act_reg == A_START) begin
                sda_oe_reg <= 1'b1;
              end else if (act_reg == A_STOP) begin
                sda_oe_reg <= 1'b0;
              end else if (act_reg == A_TX && bc_reg == BIT_LAST) begin
                nack_reg <= sda_sy[1];
              end else if (act_reg == A_RX && bc_reg != BIT_LAST) begin
                rx_reg <= {rx_reg[6:0], sda_sy[1]};
              end
            end else if (ph_reg == 2'h2) begin
              scl_reg <= (act_reg == A_STOP);
            end else if ((act_reg == A_TX || act_reg == A_RX) && bc_reg != BIT_LAST) begin
              bc_reg <= bc_reg + 4'h1;
              tx_reg <= {tx_reg[6:0], 1'b0};
              if (act_reg == A_TX) begin
                sda_oe_reg <= (bc_reg == 4'h7) ? 1'b0 : ~tx_reg[6];
              end else begin
                // ack wanted for more bytes, nack on the last
                sda_oe_reg <= (bc_reg == 4'h7) && (rem_reg != 8'h01);
                push_reg <= (bc_reg == 4'h7);
              end
            end else begin
              act_reg <= A_NEXT;
              sda_oe_reg <= (act_reg == A_RX) ? 1'b0 : sda_oe_reg;
              if (act_reg == A_TX && nack_reg) begin
                st_reg <= (step.act == A_STOP) ? st_reg : ST_FIN;
                act_reg <= A_STOP;
                scl_reg <= 1'b0;
                sda_oe_reg <= 1'b1;
                ph_reg <= 2'h0;
              end else if (act_reg == A_RX && rem_reg != 8'h01) begin
                rem_reg <= rem_reg - 8'h01;
              end else begin
                st_reg <= (act_reg == A_STOP && nack_reg) ? ST_FIN : st_reg + 4'h1;
              end
            end
          end
        end
      endcase
    end
  end

  assign bus.scl = scl_reg;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read data buffer and registered output stage

  sea_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(push_reg),
    .in_ready(f_ready),
    .in_data(rx_reg),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  assign f_pop = ~rd_valid | rd_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else if (ce && f_pop) begin
      rd_valid <= f_valid;
      rd_data <= f_data;
    end
  end
endmodule

// File: testbench/sea_chk_sva.sv
// concurrent checks on the two-wire link between host and device ends
`timescale 1ns/10ps
module sea_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus lines
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // bus conditions: sda moves while scl stays high
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  property p_rel_stop;
    s_stop |-> ##[0:6] !dev_sda_oe;
  endproperty
  a_rel_stop: assert property (p_rel_stop) else $error("sda held after stop");
  property p_rel_start;
    s_start |-> ##[0:6] !dev_sda_oe;
  endproperty
  a_rel_start: assert property (p_rel_start) else $error("sda held after start");
  // device only moves sda while scl is low, else it fakes a condition
  property p_chg_low;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_chg_low: assert property (p_chg_low) else $error("device sda moved, scl high");
  property p_drive_bound;
    $rose(dev_sda_oe) |-> ##[1:300] !dev_sda_oe;
  endproperty
  a_drive_bound: assert property (p_drive_bound) else $error("device never freed");
  property p_dev_only;
    dev_sda_oe && scl |-> !host_sda_oe;
  endproperty
  a_dev_only: assert property (p_dev_only) else $error("two drivers on sda");
  property p_start_hold;
    s_start |=> scl [*2];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("scl fell at start");
  property p_idle_stop;
    s_stop |=> scl [*4];
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("scl moved after stop");
  property p_rst_idle;
    $fell(rst) |-> scl && !dev_sda_oe && !host_sda_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("bus not idle at reset");
endmodule

// File: testbench/tb_serial_eeprom_read_ack_poll.sv
// self-checking bench joining host and device ends across the link
`timescale 1ns/10ps
module tb_serial_eeprom_read_ack_poll;
  import sea_pkg::*;
  localparam int MSZ = 32;
  localparam logic [2:0] SEL = 3'h5;
  logic clk = 0, link_clk = 0, rst = 1, cmd_valid = 0, rd_ready = 0;
  logic cmd_ready, done, done_ack_ok, rd_valid, busy, got_done = 0, got_ok = 0;
  logic [7:0] rd_data, cmd_data = 8'h00, cmd_len = 8'h00;
  logic [15:0] cmd_addr = 16'h0000;
  logic [2:0] cmd_sel = 3'h0;
  sea_op_e cmd_op = OP_POLL;
  int num_errors = 0, n_tests = 0;
  ////////////////////////////////////////
  // link clock phase offset keeps the domains unrelated
  always #50 clk = ~clk;
  initial #7 forever #32 link_clk = ~link_clk;
  sea_if sea_if_i();
  // small memory makes the wrap reachable
  sea_dev #(.AW(5), .TWR_CYCLES(600)) sea_dev_i (.clk(clk), .link_clk(link_clk),
    .rst(rst), .ce(1'b1), .bus(sea_if_i), .chip_select_pins(SEL), .busy(busy));
  sea_host #(.QTR(8), .DEPTH(FIFO_DEPTH)) sea_host_i (.clk(clk), .rst(rst), .ce(1'b1),
    .bus(sea_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_len(cmd_len),
    .done(done), .done_ack_ok(done_ack_ok), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data));
  sea_chk sea_chk_i (.clk(clk), .rst(rst), .scl(sea_if_i.scl), .sda(sea_if_i.sda),
    .host_sda_oe(sea_if_i.host_sda_oe), .dev_sda_oe(sea_if_i.dev_sda_oe));
  // done is a one-cycle pulse, so latch it
  always @(posedge clk) begin
    if (done === 1'b1) begin
      got_done <= 1'b1;
      got_ok <= done_ack_ok;
    end
  end
  ////////////////////////////////////////
  function automatic logic [7:0] d(int a);
    // msb set in every byte, so a stalled read leaves sda released
    return 8'(a % MSZ) ^ 8'ha5;
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang(string what);
    num_errors++;
    $display("mismatch %s exp event seen timeout", what);
    summarize();
  endtask
  task automatic wait_done();
    int k;
    for (k = 0; k < 40000 && got_done !== 1'b1; k++) @(negedge clk);
    if (k == 40000) hang("done");
  endtask
  task automatic cmd(sea_op_e op, logic [2:0] sel, int a, int len, bit wt);
    int k;
    for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge clk);
    if (k == 100) hang("cmd_ready");
    cmd_op = op;
    cmd_sel = sel;
    cmd_addr = 16'(a);
    cmd_data = d(a);
    cmd_len = 8'(len);
    got_done = 0;
    cmd_valid = 1;
    @(negedge clk);
    cmd_valid = 0;
    if (wt) wait_done();
  endtask
  task automatic collect(int a, int n);
    int k;
    for (int i = 0; i < n; i++) begin
      for (k = 0; k < 2000 && rd_valid !== 1'b1; k++) @(negedge clk);
      if (k == 2000) hang("rd_valid");
      check("rd_data", rd_data, d(a + i));
      rd_ready = 1;
      @(negedge clk);
      rd_ready = 0;
    end
  endtask
  task automatic write_poll(int a);
    int k;
    cmd(OP_WRITE, SEL, a, 1, 1);
    check("write_ack", {7'h0, got_ok}, 8'h01);
    check("busy", {7'h0, busy}, 8'h01);
    cmd(OP_POLL, SEL, 0, 1, 1);
    check("poll_busy", {7'h0, got_ok}, 8'h00);
    for (k = 0; k < 20 && got_ok !== 1'b1; k++) cmd(OP_POLL, SEL, 0, 1, 1);
    check("poll_free", {7'h0, got_ok}, 8'h01);
  endtask
  ////////////////////////////////////////
  // main sequence; every read byte is compared against the written pattern
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    repeat (4) @(negedge clk);
    cmd(OP_POLL, 3'h2, 0, 1, 1);
    check("sel_miss", {7'h0, got_ok}, 8'h00);
    for (int a = 0; a < MSZ; a++) write_poll(a);
    cmd(OP_RD_RAND, SEL, MSZ - 1, 1, 0);
    collect(MSZ - 1, 1);
    wait_done();
    cmd(OP_RD_CUR, SEL, 0, 1, 0);
    collect(0, 1);
    wait_done();
    check("cur_ack", {7'h0, got_ok}, 8'h01);
    cmd(OP_RD_CUR, SEL, 0, 1, 0);
    collect(1, 1);
    wait_done();
    // overfill the fifo: host must stall rather than drop bytes
    cmd(OP_RD_RAND, SEL, 20, 36, 0);
    repeat (11000) @(negedge clk);
    check("stall", {7'h0, got_done}, 8'h00);
    collect(20, 36);
    wait_done();
    check("seq_ack", {7'h0, got_ok}, 8'h01);
    summarize();
  end
endmodule
